//--- rtl/sei_regs.svh
// Constants of the two-wire serial memory slave: slave code, layout, timing.
// Assumes inclusion by bare name from the design modules only.
// Overview of operation
// RULE1 - Acknowledge a matching slave address by pulling data low in clock nine.
// RULE2 - In a write session acknowledge the address byte and every data byte.
// RULE3 - In a read session send a byte, release data in clock nine, repeat.
// RULE4 - The master ends a read with a missing acknowledge and then a STOP.
// RULE5 - Byte write is START, write address, memory address, data, STOP.
// RULE6 - STOP after a write starts the internal cycle; stay silent throughout.
// RULE7 - A page write carries at most sixteen data bytes into one cycle.
// RULE8 - Each received data byte bumps only the four low address bits.
// RULE9 - Past sixteen bytes the page address wraps and newer bytes replace.
// RULE10 - STOP after page data commits all buffered bytes in one cycle.
// RULE11 - While busy a write address gets no acknowledge; afterwards it does.
// RULE12 - The master may poll with START and write address right after STOP.
// RULE13 - Protect input high refuses all writes; low or open has no effect.
// RULE14 - Protect sampled on last falling clock before first data byte.
// RULE15 - Every memory byte holds the erased value before any write.
// RULE16 - Read address: acknowledge and shift out the byte at the pointer.
// RULE17 - Missing acknowledge then STOP returns the slave to idle.
// RULE18 - Random read: dummy write of the address, then repeated START, read.
// RULE19 - A master acknowledge makes the slave send the next address byte.
// RULE20 - Reads increment the full pointer and wrap to zero at memory end.
// RULE21 - Slave byte: fixed nibble, three select or address bits, direction.
// RULE22 - Data sampled on rising clock; slave drive changes after falling.
// RULE23 - START and STOP are data edges while clock is high; need START.
// RULE24 - The pointer survives between sessions for current-address reads.
`ifndef SEI_REGS_SVH
`define SEI_REGS_SVH
`define SEI_DEV_CODE 4'hA
`define SEI_ERASED 8'hFF
`define SEI_ADDR_W 11
`define SEI_PAGE_W 4
`define SEI_CNT_PRE 4'hF
`define SEI_LAST_BIT 4'h7
`define SEI_ACK_BIT 4'h8
`define SEI_WRITE_MS 5
`define SEI_CLK_HZ 25000000
`define SEI_WRITE_CYC (`SEI_WRITE_MS * (`SEI_CLK_HZ / 1000))
`define SEI_PIN_IDLE 6'h30
`endif

//--- rtl/sei_pkg.sv
// Types shared by the serial memory slave modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sei_pkg;
    // Protocol engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WADDR,
        ST_WDATA,
        ST_READ
    } sei_state_type;

    // Pin levels sampled together through the synchroniser.
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic [2:0] sel;
    } sei_pins_type;
endpackage : sei_pkg
`default_nettype wire

//--- rtl/sei_mem.sv
// Byte-wide memory with one write port and a registered read port.
// Assumes one clock; contents start erased and are not touched by reset.
`timescale 1ns/100ps
`default_nettype none
`include "sei_regs.svh"

module sei_mem #(
    parameter int AW = 4 // Address width in bits.
) (
    input wire logic i_clk, // Clock.
    input wire logic i_en, // Clock enable, low freezes the memory.
    input wire logic i_we, // Write strobe.
    input wire logic [AW-1:0] i_waddr, // Write address.
    input wire logic [7:0] i_wdata, // Write data.
    input wire logic [AW-1:0] i_raddr, // Read address.
    output logic [7:0] o_rdata // Read data, one cycle after address.
);
    logic [7:0] mem [0:(1<<AW)-1];

    // The array is erased at start-up; reset cannot reach it in real cells.
    initial
    begin
        for (int i = 0; i < (1 << AW); i++)
        begin
            mem[i] = `SEI_ERASED; // RULE15
        end
    end

    // Write port.
    always @(posedge i_clk)
    begin
        if (i_en && i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read keeps the output free of address glitches.
    always_ff @(posedge i_clk)
    begin
        if (i_en)
        begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : sei_mem
`default_nettype wire

//--- rtl/sei_slave.sv
// Two-wire serial memory slave: pin synchroniser, protocol engine, page
// buffer and commit sequencer on the link clock, write timer on sys clock.
// Assumes an external pull-up on the data wire and a free-running link
// clock many times faster than the bus clock, used to oversample it.
`timescale 1ns/100ps
`default_nettype none
`include "sei_regs.svh"

module sei_slave #(
    parameter int ADDR_W = `SEI_ADDR_W, // Memory address width, 9 to 11.
    parameter int WRITE_CYCLES = `SEI_WRITE_CYC // Write cycle in sys clocks.
) (
    input wire logic i_clk_sys, // System clock, 25 MHz.
    input wire logic i_rst_n, // Asynchronous reset, active low.
    input wire logic i_clk_en, // Clock enable, low freezes all state.
    input wire logic i_clk_link, // Oversampling clock of the bus logic.
    input wire logic i_scl, // Serial clock from the master.
    input wire logic i_sda, // Level seen on the data wire.
    output logic o_sda, // Data drive level, always low.
    output logic o_sda_oe_n, // Data drive enable, low pulls the wire.
    input wire logic i_wp, // Write protect, high blocks writes.
    input wire logic [2:0] i_device_select_pins, // Device select straps.
    output logic o_busy // Internal write cycle in progress.
);
    localparam int PW = `SEI_PAGE_W;
    localparam int SEL_UP = ADDR_W - 8;
    localparam int TW = $clog2(WRITE_CYCLES + 1);

    logic [1:0] en_sync;
    logic en_l;
    sei_pkg::sei_pins_type pin_in;
    sei_pkg::sei_pins_type pin_m;
    sei_pkg::sei_pins_type pin_s;
    sei_pkg::sei_pins_type pin_q;
    sei_pkg::sei_state_type state;
    sei_pkg::sei_state_type next_state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic sda_low, acked, is_rd, mack, wp_lat, dirty;
    logic [ADDR_W-1:0] ptr, ptr_q, commit_addr;
    logic [(1<<PW)-1:0] valid;
    logic commit_run, wr_d, req_tog, req_pend;
    logic [PW:0] cidx;
    logic [PW-1:0] cidx_d;
    logic [1:0] busy_sync;
    logic [2:0] tog_sync;
    logic [TW-1:0] timer;
    logic busy_sys, tog_ev;
    logic [7:0] mem_rdata, buf_rdata;
    logic [2:0] sel_ok;
    logic active, scl_rise, scl_fall, start_c, stop_c;
    logic byte_done, ack_end, dev_hit, busy_l, dev_ack, waddr_done;
    logic wdat_ok, rd_sent, rd_load, rd_shift, ack_now, commit_go;
    logic commit_end;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers on the link clock.

    // The enable crosses by two flops; it cannot gate its own synchroniser.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
            en_sync <= 2'h0;
        else
            en_sync <= {en_sync[0], i_clk_en};
    end
    assign en_l = en_sync[1];
    assign pin_in = '{scl: i_scl, sda: i_sda, wp: i_wp,
                      sel: i_device_select_pins};

    // Two flops per pin, then a third copy for edge detection.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            // Idle bus levels, so that release shows no false edge.
            pin_m <= `SEI_PIN_IDLE;
            pin_s <= `SEI_PIN_IDLE;
            pin_q <= `SEI_PIN_IDLE;
        end
        else if (en_l)
        begin
            pin_m <= pin_in;
            pin_s <= pin_m;
            pin_q <= pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus event decode.

    // Edges and conditions; every event is dead while the clock is frozen.
    assign scl_rise = en_l & pin_s.scl & ~pin_q.scl;
    assign scl_fall = en_l & ~pin_s.scl & pin_q.scl;
    assign start_c = en_l & pin_s.scl & pin_q.scl & pin_q.sda & ~pin_s.sda;
    assign stop_c = en_l & pin_s.scl & pin_q.scl & ~pin_q.sda & pin_s.sda;
    assign active = (state != sei_pkg::ST_IDLE);
    assign byte_done = scl_fall & active & (cnt == `SEI_LAST_BIT);
    assign ack_end = scl_fall & active & (cnt == `SEI_ACK_BIT);

    // Select bits that carry memory address always match; others need pins.
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sel
            if (g < SEL_UP)
            begin : g_addr
                assign sel_ok[g] = 1'b1;
            end
            else
            begin : g_pin
                assign sel_ok[g] = (sh[g+1] == pin_s.sel[g]); // RULE21
            end
        end
    endgenerate
    assign dev_hit = (sh[7:4] == `SEI_DEV_CODE) & (&sel_ok); // RULE21

    // Byte-level decisions taken when the eighth bit has been clocked.
    assign busy_l = req_pend | busy_sync[1] | commit_run;
    assign dev_ack = byte_done & (state == sei_pkg::ST_DEV) & dev_hit
                     & ~busy_l; // RULE1 RULE11 RULE12
    assign waddr_done = byte_done & (state == sei_pkg::ST_WADDR); // RULE2
    assign wdat_ok = byte_done & (state == sei_pkg::ST_WDATA)
                     & ~wp_lat; // RULE13 RULE14
    assign rd_sent = byte_done & (state == sei_pkg::ST_READ);
    assign ack_now = dev_ack | waddr_done | wdat_ok; // RULE2
    assign rd_load = ack_end & (((state == sei_pkg::ST_DEV) & acked & is_rd)
                     | ((state == sei_pkg::ST_READ) & mack)); // RULE16 RULE19
    assign rd_shift = scl_fall & (state == sei_pkg::ST_READ)
                      & (cnt < `SEI_LAST_BIT);
    assign commit_go = stop_c & (state == sei_pkg::ST_WDATA)
                       & dirty; // RULE6 RULE10
    assign commit_end = commit_run & cidx[PW];

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine.

    // Next state at the end of each acknowledge clock.
    always_comb
    begin
        next_state = state;
        case (state)
            sei_pkg::ST_DEV:
                next_state = !acked ? sei_pkg::ST_IDLE :
                             (is_rd ? sei_pkg::ST_READ : sei_pkg::ST_WADDR);
            sei_pkg::ST_WADDR:
                next_state = sei_pkg::ST_WDATA; // RULE5
            sei_pkg::ST_WDATA:
                next_state = acked ? sei_pkg::ST_WDATA : sei_pkg::ST_IDLE;
            sei_pkg::ST_READ:
                next_state = mack ? sei_pkg::ST_READ :
                             sei_pkg::ST_IDLE; // RULE4 RULE17
            default:
                next_state = sei_pkg::ST_IDLE;
        endcase
    end

    // The bit counter sits at a pre-value after START so the first falling
    // clock, which carries no bit, rolls it to zero.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= sei_pkg::ST_IDLE;
            cnt <= `SEI_CNT_PRE;
        end
        else if (start_c)
        begin
            state <= sei_pkg::ST_DEV; // RULE23
            cnt <= `SEI_CNT_PRE;
        end
        else if (stop_c)
            state <= sei_pkg::ST_IDLE; // RULE17 RULE23
        else if (scl_fall && active)
        begin
            cnt <= (cnt == `SEI_ACK_BIT) ? 4'h0 : cnt + 4'h1;
            if (ack_end)
                state <= next_state;
        end
    end

    // Shift register and data drive; drive moves on a falling clock, or is released by START or STOP.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh <= 8'h00;
            sda_low <= 1'b0;
            acked <= 1'b0;
            is_rd <= 1'b0;
            mack <= 1'b0;
        end
        else if (start_c || stop_c)
            sda_low <= 1'b0;
        else if (scl_rise && active && state != sei_pkg::ST_READ && !cnt[3])
            sh <= {sh[6:0], pin_s.sda}; // RULE22
        else if (scl_rise && state == sei_pkg::ST_READ && cnt == `SEI_ACK_BIT)
            mack <= !pin_s.sda; // RULE19
        else if (byte_done)
        begin
            acked <= ack_now;
            is_rd <= sh[0];
            sda_low <= ack_now; // RULE1 RULE3 RULE22
        end
        else if (rd_load)
        begin
            sh <= mem_rdata;
            sda_low <= !mem_rdata[7]; // RULE16 RULE22
        end
        else if (ack_end)
            sda_low <= 1'b0;
        else if (rd_shift)
        begin
            sh <= {sh[6:0], 1'b0};
            sda_low <= !sh[6]; // RULE3 RULE22
        end
    end

    // The pointer is never cleared by a session, only by reset.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ptr <= '0;
        else if (dev_ack && !sh[0])
            ptr <= {sh[SEL_UP:1], ptr[7:0]};
        else if (waddr_done)
            ptr[7:0] <= sh; // RULE18 RULE24
        else if (wdat_ok)
            ptr[PW-1:0] <= ptr[PW-1:0] + 1'b1; // RULE8 RULE9
        else if (rd_sent)
            ptr <= ptr + 1'b1; // RULE20 RULE24
    end

    // Protect level, pending data and the handover to the timer.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wp_lat <= 1'b0;
            dirty <= 1'b0;
            valid <= '0;
            req_tog <= 1'b0;
            req_pend <= 1'b0;
        end
        else if (en_l)
        begin
            if (ack_end && state == sei_pkg::ST_WADDR)
                wp_lat <= pin_s.wp; // RULE14
            if (commit_go)
                req_tog <= ~req_tog;
            req_pend <= commit_go | (req_pend & !busy_sync[1]);
            if (start_c && !commit_run)
            begin
                dirty <= 1'b0;
                valid <= '0;
            end
            else if (wdat_ok)
            begin
                dirty <= 1'b1;
                valid[ptr[PW-1:0]] <= 1'b1; // RULE9
            end
            else if (commit_go)
                dirty <= 1'b0;
            else if (commit_end)
                valid <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commit sequencer: copies valid buffer entries into the array.

    // One read per cycle, write a cycle later when the buffer data is out.
    always_ff @(posedge i_clk_link or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            commit_run <= 1'b0;
            cidx <= '0;
            cidx_d <= '0;
            wr_d <= 1'b0;
            busy_sync <= 2'h0;
            ptr_q <= '0;
        end
        else if (en_l)
        begin
            if (commit_go)
            begin
                commit_run <= 1'b1; // RULE10
                cidx <= '0;
            end
            else if (commit_run)
            begin
                cidx <= cidx + 1'b1;
                commit_run <= !commit_end;
            end
            wr_d <= commit_run & !cidx[PW] & valid[cidx[PW-1:0]];
            cidx_d <= cidx[PW-1:0];
            busy_sync <= {busy_sync[0], busy_sys};
            ptr_q <= ptr;
        end
    end
    assign commit_addr = {ptr[ADDR_W-1:PW], cidx_d};

    // Sixteen-entry page buffer; a later byte simply overwrites its slot.
    sei_mem #(.AW(PW)) u_page ( // RULE7
        .i_clk(i_clk_link),
        .i_en(en_l),
        .i_we(wdat_ok),
        .i_waddr(ptr[PW-1:0]),
        .i_wdata(sh),
        .i_raddr(cidx[PW-1:0]),
        .o_rdata(buf_rdata)
    );

    // The array; its read port always follows the pointer.
    sei_mem #(.AW(ADDR_W)) u_array (
        .i_clk(i_clk_link),
        .i_en(en_l),
        .i_we(wr_d),
        .i_waddr(commit_addr),
        .i_wdata(buf_rdata),
        .i_raddr(ptr),
        .o_rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write-cycle timer on the system clock.

    // A toggle carries the start request across; the busy level comes back
    // through two flops, so the link side holds busy itself until it lands.
    assign tog_ev = tog_sync[2] ^ tog_sync[1];
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tog_sync <= 3'h0;
            busy_sys <= 1'b0;
            timer <= '0;
        end
        else if (i_clk_en)
        begin
            tog_sync <= {tog_sync[1:0], req_tog};
            if (tog_ev)
            begin
                busy_sys <= 1'b1; // RULE6
                timer <= TW'(WRITE_CYCLES - 1);
            end
            else if (timer != '0)
                timer <= timer - 1'b1;
            else
                busy_sys <= 1'b0;
        end
    end

    // The wire is only ever pulled low; the pull-up makes the ones.
    assign o_sda = 1'b0;
    assign o_sda_oe_n = !sda_low; // RULE6
    assign o_busy = busy_sys;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_dev_hit;
        byte_done && state == sei_pkg::ST_DEV && dev_hit && !busy_l;
    endsequence
    sequence s_commit;
        commit_go ##1 commit_run;
    endsequence

    a_ack_address: assert property (@(posedge i_clk_link) // RULE1
        disable iff (!i_rst_n) s_dev_hit |=> sda_low)
        else $error("Matching slave address not acknowledged.");
    a_ack_waddr: assert property (@(posedge i_clk_link) // RULE2
        disable iff (!i_rst_n)
        byte_done && state == sei_pkg::ST_WADDR |=> sda_low && ptr[7:0] == sh)
        else $error("Memory address byte not taken and acknowledged.");
    a_read_release: assert property (@(posedge i_clk_link) // RULE3
        disable iff (!i_rst_n) rd_sent |=> !sda_low)
        else $error("Data line not released in the acknowledge clock.");
    a_busy_quiet: assert property (@(posedge i_clk_link) // RULE6
        disable iff (!i_rst_n) busy_l |-> o_sda_oe_n)
        else $error("Data line driven during the write cycle.");
    a_poll_nack: assert property (@(posedge i_clk_link) // RULE11
        disable iff (!i_rst_n)
        byte_done && state == sei_pkg::ST_DEV && busy_l |=> !sda_low ##0 !acked)
        else $error("Address acknowledged while busy.");
    a_page_wrap: assert property (@(posedge i_clk_link) // RULE8
        disable iff (!i_rst_n) wdat_ok |=>
        ptr[PW-1:0] == PW'(ptr_q[PW-1:0] + 1'b1)
        && ptr[ADDR_W-1:PW] == ptr_q[ADDR_W-1:PW])
        else $error("Page write address did not wrap inside the page.");
    a_wp_reject: assert property (@(posedge i_clk_link) // RULE14
        disable iff (!i_rst_n)
        byte_done && state == sei_pkg::ST_WDATA && wp_lat |=> !sda_low && !dirty)
        else $error("Protected write was acknowledged or buffered.");
    a_commit_once: assert property (@(posedge i_clk_link) // RULE10
        disable iff (!i_rst_n) s_commit |-> commit_run[*8] ##10 !commit_run)
        else $error("Commit did not take exactly one buffer pass.");
    a_read_incr: assert property (@(posedge i_clk_link) // RULE20
        disable iff (!i_rst_n) rd_sent |=> ptr == ADDR_W'(ptr_q + 1'b1))
        else $error("Read pointer did not advance over the whole memory.");
    a_stop_idle: assert property (@(posedge i_clk_link) // RULE17
        disable iff (!i_rst_n) stop_c |=> state == sei_pkg::ST_IDLE && !sda_low)
        else $error("STOP did not return the slave to idle.");
    a_busy_hold: assert property (@(posedge i_clk_sys) // RULE6
        disable iff (!i_rst_n) tog_ev && i_clk_en |=> busy_sys[*8])
        else $error("Write cycle ended too early.");
endmodule : sei_slave
`default_nettype wire

//--- sim/sei_master.sv
// Bus master model that drives the serial clock and all conditions.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module sei_master #(
    parameter int HALF = 3 // Half bus clock period in bench clocks.
) (
    input wire logic i_clk, // Bench clock, paces the bus.
    input wire logic i_sda, // Resolved data wire.
    output logic o_scl, // Bus clock, stands high between frames.
    output logic o_sda // Data drive, 0 pulls the wire low.
);
    logic r;

    // Both lines start released, so the wire idles high.
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // Data only moves while the clock is low and is read while high.
    task automatic bit_io(input logic b, output logic s);
        o_sda <= b;
        tick(HALF);
        o_scl <= 1'b1;
        tick(HALF);
        s = i_sda;
        o_scl <= 1'b0;
        tick(1);
    endtask : bit_io

    // Data falls while the clock is high; also serves as repeated start.
    task automatic start();
        o_sda <= 1'b1;
        tick(HALF);
        o_scl <= 1'b1;
        tick(HALF);
        o_sda <= 1'b0;
        tick(HALF);
        o_scl <= 1'b0;
        tick(1);
    endtask : start

    // Data rises while the clock is high.
    task automatic stop();
        o_sda <= 1'b0;
        tick(HALF);
        o_scl <= 1'b1;
        tick(HALF);
        o_sda <= 1'b1;
        tick(HALF);
    endtask : stop

    // Byte goes out MSB first; the ninth clock reads the acknowledge.
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send

    // A missing acknowledge marks the last byte of a read.
    task automatic recv(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~ack, r);
    endtask : recv
endmodule : sei_master
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the serial memory slave.
// Assumes a short write cycle parameter so the run stays brief.
`timescale 1ns/100ps
`default_nettype none
`define SEI_CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end

module tb_top;
    localparam int WR_CYC = 200;
    logic clk_sys, clk_link, rst_n, wp, scl, m_sda, oe_n, sda_lvl, busy;
    wire logic line;
    int err_total = 0;
    int samples_checked = 0;

    // Open-drain wire with pull-up: low if either party pulls.
    assign line = (oe_n ? 1'b1 : sda_lvl) & m_sda;

    sei_slave #(.WRITE_CYCLES(WR_CYC)) uut (.i_clk_sys(clk_sys),
        .i_rst_n(rst_n), .i_clk_en(1'b1), .i_clk_link(clk_link),
        .i_scl(scl), .i_sda(line), .o_sda(sda_lvl), .o_sda_oe_n(oe_n),
        .i_wp(wp), .i_device_select_pins(3'h0), .o_busy(busy));
    sei_master bus (.i_clk(clk_sys), .i_sda(line), .o_scl(scl),
        .o_sda(m_sda));

    // Two unrelated clocks: 40 ns system, 6 ns link.
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        clk_link = 1'b0;
        #1.7;
        forever #3 clk_link = ~clk_link;
    end

    task automatic summarize();
        $display("checked=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // Write address with high bits in the slave byte, then the low byte.
    task automatic addr_w(input logic [10:0] a);
        logic ack;
        bus.start();
        bus.send({4'hA, a[10:8], 1'b0}, ack);
        `SEI_CHK(ack, 1'b1)
        bus.send(a[7:0], ack);
        `SEI_CHK(ack, 1'b1)
    endtask : addr_w

    // Dummy write of the address, then a repeated start for reading.
    task automatic rd_from(input logic [10:0] a);
        logic ack;
        addr_w(a);
        bus.start();
        bus.send(8'hA1, ack);
        `SEI_CHK(ack, 1'b1)
    endtask : rd_from

    // Poll with write addresses until acknowledged, with a bounded count.
    task automatic wait_ready();
        logic ack;
        int n;
        n = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && n < 20)
        begin
            bus.start();
            bus.send(8'hA0, ack);
            n++;
        end
        bus.stop();
        `SEI_CHK(ack, 1'b1)
        if (ack !== 1'b1)
            summarize();
    endtask : wait_ready

    // Protected write is refused; unprotected write of two bytes lands.
    task automatic t_wp();
        logic ack;
        bus.start();
        bus.send(8'hB0, ack);
        `SEI_CHK(ack, 1'b0)
        bus.stop();
        wp <= 1'b1;
        addr_w(11'h000);
        bus.send(8'h11, ack);
        `SEI_CHK(ack, 1'b0)
        bus.stop();
        repeat (20) @(posedge clk_sys);
        `SEI_CHK(busy, 1'b0)
        wp <= 1'b0;
        addr_w(11'h000);
        bus.send(8'h5A, ack);
        `SEI_CHK(ack, 1'b1)
        bus.send(8'h5B, ack);
        bus.stop();
        wait_ready();
    endtask : t_wp

    // Eighteen bytes wrap inside the page; busy refuses, then reads back.
    task automatic t_page();
        logic [7:0] ex [16];
        logic [7:0] d;
        logic ack;
        int n;
        addr_w(11'h10E);
        for (int k = 0; k < 18; k++)
        begin
            bus.send(8'h30 + k[7:0], ack);
            `SEI_CHK(ack, 1'b1)
            ex[(14 + k) % 16] = 8'h30 + k[7:0];
        end
        bus.stop();
        n = 0;
        while (busy !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys);
            n++;
        end
        `SEI_CHK(busy, 1'b1)
        if (busy !== 1'b1)
            summarize();
        bus.start();
        bus.send(8'hA0, ack);
        `SEI_CHK(ack, 1'b0)
        bus.stop();
        wait_ready();
        rd_from(11'h100);
        for (int k = 0; k < 16; k++)
        begin
            bus.recv(k < 15, d);
            `SEI_CHK(d, ex[k])
        end
        bus.stop();
    endtask : t_page

    // Read wraps from memory end to zero; pointer persists.
    task automatic t_wrap();
        logic [7:0] d;
        logic ack;
        rd_from(11'h7FF);
        bus.recv(1'b1, d);
        `SEI_CHK(d, 8'hFF)
        bus.recv(1'b0, d);
        `SEI_CHK(d, 8'h5A)
        bus.stop();
        bus.start();
        bus.send(8'hA1, ack);
        `SEI_CHK(ack, 1'b1)
        bus.recv(1'b0, d);
        `SEI_CHK(d, 8'h5B)
        bus.stop();
    endtask : t_wrap

    // Main sequence after ten clocks of reset.
    initial
    begin
        rst_n = 1'b0;
        wp = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        t_wp();
        t_page();
        t_wrap();
        summarize();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
